// File: src/rtam_top.sv
// alarm repeat decode and autonomous external power control with ahb-lite registers
// Notes on behaviour
// [RULE1] code 0000 half second, 0001 each second
// [RULE2] 0010 ten seconds, 0011 each minute
// [RULE3] 0100 ten minutes, 0101 each hour
// [RULE4] daily to yearly; feb 29 not annual
// [RULE5] power on, wait stable, sample, power off
// [RULE6] cycling runs alone, no processor needed
// [RULE7] needs unit, enable, pin drive, source 11
// [RULE8] output polarity chosen by software bit
// [RULE9] software should set repeat forever bit
// [RULE10] active low plus open drain, external pullup; the pin here is driven at both levels while O_RTC_PIN_OE is set
// [RULE11] coarser fields than period are ignored
`timescale 1ns/1ps
module rtam_top
   import rtam_pkg::*;
(
   input  wire logic        I_CLOCK,
   input  wire logic        I_ARST_N,
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic      [31:0] O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   input  wire logic        I_HALF_TICK,
   input  wire logic        I_HALF_PHASE,
   input  wire rtam_time_t  I_NOW_TIME,
   input  wire logic        I_WAKE,
   output logic             O_RTC_PIN,
   output logic             O_RTC_PIN_OE,
   output logic             O_ALARM_PULSE,
   output logic             O_WAKE_PULSE
);

   logic        rst_s1_reg;
   logic        rst_s2_reg;
   rtam_state_t state_reg;
   rtam_state_t state_next;
   logic [7:0]  hits;
   logic        all_hit;
   logic        match;
   logic        fire;
   logic        pwc_go;
   logic        take;
   logic [31:0] rd_data;
   logic [3:0]  mc;

   always_ff @(posedge I_CLOCK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   assign mc = state_reg.ctrl.alarm_repeat_mask_code;

   // [RULE11] finer fields only
   rtam_fld_cmp #(.W(4)) u_sec1 (.i_en(mc >= RTAM_MASK_10S), .i_now(I_NOW_TIME.sec1),
      .i_alm(state_reg.alm.sec1), .o_hit(hits[0]));
   rtam_fld_cmp #(.W(3)) u_sec10 (.i_en(mc >= RTAM_MASK_MIN), .i_now(I_NOW_TIME.sec10),
      .i_alm(state_reg.alm.sec10), .o_hit(hits[1]));
   rtam_fld_cmp #(.W(4)) u_min1 (.i_en(mc >= RTAM_MASK_10M), .i_now(I_NOW_TIME.min1),
      .i_alm(state_reg.alm.min1), .o_hit(hits[2]));
   rtam_fld_cmp #(.W(3)) u_min10 (.i_en(mc >= RTAM_MASK_HOUR), .i_now(I_NOW_TIME.min10),
      .i_alm(state_reg.alm.min10), .o_hit(hits[3]));
   rtam_fld_cmp #(.W(6)) u_hour (.i_en(mc >= RTAM_MASK_DAY), .i_now(I_NOW_TIME.hour),
      .i_alm(state_reg.alm.hour), .o_hit(hits[4]));
   rtam_fld_cmp #(.W(3)) u_wday (.i_en(mc == RTAM_MASK_WEEK), .i_now(I_NOW_TIME.wday),
      .i_alm(state_reg.alm.wday), .o_hit(hits[5]));
   rtam_fld_cmp #(.W(6)) u_day (.i_en(mc >= RTAM_MASK_MONTH), .i_now(I_NOW_TIME.day),
      .i_alm(state_reg.alm.day), .o_hit(hits[6]));
   // [RULE4] month and day compared, so feb 29 fires in leap years only
   rtam_fld_cmp #(.W(5)) u_month (.i_en(mc == RTAM_MASK_YEAR), .i_now(I_NOW_TIME.month),
      .i_alm(state_reg.alm.month), .o_hit(hits[7]));

   assign all_hit = &hits;

   always_comb
   begin
      match = 1'b0;
      case (mc)
         // [RULE1] every half-second tick
         RTAM_MASK_HALF:
            match = I_HALF_TICK;
         // [RULE1] [RULE2] [RULE3] [RULE4] on whole-second edge
         RTAM_MASK_SEC, RTAM_MASK_10S, RTAM_MASK_MIN, RTAM_MASK_10M, RTAM_MASK_HOUR,
         RTAM_MASK_DAY, RTAM_MASK_WEEK, RTAM_MASK_MONTH, RTAM_MASK_YEAR:
            match = I_HALF_TICK && !I_HALF_PHASE && all_hit;
         default:
            match = 1'b0;
      endcase
   end

   assign fire = match && state_reg.ctrl.alarm_en && state_reg.ctrl.clock_unit_on;

   // [RULE7] all four enables
   assign pwc_go = state_reg.ctrl.clock_unit_on && state_reg.ctrl.power_ctl_on
                   && state_reg.ctrl.clock_pin_drive_on
                   && (state_reg.ctrl.clock_pin_source_sel == RTAM_SRC_PWC);

   assign take = I_HSEL && I_HTRANS[1] && I_HREADY;

   always_comb
   begin
      rd_data = 32'h0000_0000;
      if (I_HADDR[31:8] == 24'h00_0000)
      begin
         case (I_HADDR[7:0])
            RTAM_CTRL_ADDR:
               rd_data = state_reg.ctrl;
            RTAM_ALMMS_ADDR:
            begin
               rd_data[RTAM_SEC1_LSB +: 4]  = state_reg.alm.sec1;
               rd_data[RTAM_SEC10_LSB +: 3] = state_reg.alm.sec10;
               rd_data[RTAM_MIN1_LSB +: 4]  = state_reg.alm.min1;
               rd_data[RTAM_MIN10_LSB +: 3] = state_reg.alm.min10;
            end
            RTAM_ALMHD_ADDR:
            begin
               rd_data[RTAM_HOUR_LSB +: 6]  = state_reg.alm.hour;
               rd_data[RTAM_WDAY_LSB +: 3]  = state_reg.alm.wday;
               rd_data[RTAM_DAY_LSB +: 6]   = state_reg.alm.day;
               rd_data[RTAM_MONTH_LSB +: 5] = state_reg.alm.month;
            end
            RTAM_PWCT_ADDR:
               rd_data = state_reg.pwct;
            RTAM_STAT_ADDR:
            begin
               rd_data[RTAM_ST_ALARM] = state_reg.alarm_flag;
               rd_data[RTAM_ST_WAKE]  = state_reg.wake_seen;
               rd_data[RTAM_ST_BUSY]  = state_reg.pwc_st != RTAM_PWC_IDLE;
               rd_data[RTAM_ST_CNT_LSB +: 8] = state_reg.ctrl.rpt_cnt;
            end
            default:
               rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      state_next = state_reg;
      state_next.alarm_pulse = 1'b0;
      state_next.wake_pulse  = 1'b0;
      state_next.hready = 1'b1;
      state_next.hresp  = 1'b0;
      state_next.wr_pend = take && I_HWRITE;
      if (take)
         state_next.wr_addr = (I_HADDR[31:8] == 24'h00_0000) ? I_HADDR[7:0] : 8'hff;
      if (take && !I_HWRITE)
         state_next.hrdata = rd_data;

      if (state_reg.wr_pend)
      begin
         case (state_reg.wr_addr)
            RTAM_CTRL_ADDR:
               state_next.ctrl = rtam_ctrl_t'(I_HWDATA & RTAM_CTRL_WMSK);
            RTAM_ALMMS_ADDR:
            begin
               state_next.alm.sec1  = I_HWDATA[RTAM_SEC1_LSB +: 4];
               state_next.alm.sec10 = I_HWDATA[RTAM_SEC10_LSB +: 3];
               state_next.alm.min1  = I_HWDATA[RTAM_MIN1_LSB +: 4];
               state_next.alm.min10 = I_HWDATA[RTAM_MIN10_LSB +: 3];
            end
            RTAM_ALMHD_ADDR:
            begin
               state_next.alm.hour  = I_HWDATA[RTAM_HOUR_LSB +: 6];
               state_next.alm.wday  = I_HWDATA[RTAM_WDAY_LSB +: 3];
               state_next.alm.day   = I_HWDATA[RTAM_DAY_LSB +: 6];
               state_next.alm.month = I_HWDATA[RTAM_MONTH_LSB +: 5];
            end
            RTAM_PWCT_ADDR:
               state_next.pwct = rtam_pwct_t'(I_HWDATA & RTAM_PWCT_WMSK);
            RTAM_STAT_ADDR:
            begin
               // write one to clear; a same-cycle event below sets it again
               if (I_HWDATA[RTAM_ST_ALARM])
                  state_next.alarm_flag = 1'b0;
               if (I_HWDATA[RTAM_ST_WAKE])
                  state_next.wake_seen = 1'b0;
            end
            default:
               state_next.ctrl = state_next.ctrl;
         endcase
      end

      if (fire)
      begin
         state_next.alarm_flag  = 1'b1;
         state_next.alarm_pulse = 1'b1;
         // [RULE9] without repeat forever the count runs out
         if (!state_reg.ctrl.alarm_repeat_forever)
         begin
            if (state_reg.ctrl.rpt_cnt == 8'h00)
               state_next.ctrl.alarm_en = 1'b0;
            else
               state_next.ctrl.rpt_cnt = state_reg.ctrl.rpt_cnt - 8'h01;
         end
      end

      state_next.wake_s1 = I_WAKE;
      state_next.wake_s2 = state_reg.wake_s1;

      // [RULE5] [RULE6] sequence started by the alarm and timed by half-second ticks, no cpu involvement
      case (state_reg.pwc_st)
         RTAM_PWC_IDLE:
         begin
            if (fire && pwc_go)
            begin
               state_next.pwc_st  = RTAM_PWC_STAB;
               state_next.pwc_cnt = state_reg.pwct.stab_ticks;
            end
         end
         RTAM_PWC_STAB:
         begin
            if (I_HALF_TICK)
            begin
               if (state_reg.pwc_cnt <= 8'h01)
               begin
                  state_next.pwc_st  = RTAM_PWC_SAMPLE;
                  state_next.pwc_cnt = state_reg.pwct.sample_ticks;
               end
               else
                  state_next.pwc_cnt = state_reg.pwc_cnt - 8'h01;
            end
         end
         RTAM_PWC_SAMPLE:
         begin
            if (state_reg.wake_s2 && !state_reg.wake_seen)
               state_next.wake_pulse = 1'b1;
            if (state_reg.wake_s2)
               state_next.wake_seen = 1'b1;
            if (I_HALF_TICK)
            begin
               if (state_reg.pwc_cnt <= 8'h01)
                  state_next.pwc_st = RTAM_PWC_IDLE;
               else
                  state_next.pwc_cnt = state_reg.pwc_cnt - 8'h01;
            end
         end
         default:
            state_next.pwc_st = RTAM_PWC_IDLE;
      endcase
      // [RULE7] losing any enable ends the sequence at once; the device powers down unless the pin source was changed
      if (!pwc_go)
         state_next.pwc_st = RTAM_PWC_IDLE;

      state_next.pin_oe = state_next.ctrl.clock_pin_drive_on && state_next.ctrl.clock_unit_on;
      case (state_next.ctrl.clock_pin_source_sel)
         // [RULE8] on level equals polarity bit
         RTAM_SRC_PWC:
            state_next.pin = (state_next.pwc_st != RTAM_PWC_IDLE) ? state_next.ctrl.power_ctl_polarity
                                                                   : !state_next.ctrl.power_ctl_polarity;
         RTAM_SRC_ALARM:
            state_next.pin = state_next.alarm_pulse;
         RTAM_SRC_HALF:
            state_next.pin = I_HALF_PHASE;
         default:
            state_next.pin = 1'b0;
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge rst_s2_reg)
   begin
      if (!rst_s2_reg)
      begin
         state_reg        <= '0;
         state_reg.hready <= 1'b1;
         state_reg.ctrl   <= rtam_ctrl_t'(RTAM_CTRL_RST);
         state_reg.pwct   <= rtam_pwct_t'(RTAM_PWCT_RST);
         state_reg.pwc_st <= RTAM_PWC_IDLE;
      end
      else
         state_reg <= state_next;
   end

   assign O_HRDATA      = state_reg.hrdata;
   assign O_HREADYOUT   = state_reg.hready;
   assign O_HRESP       = state_reg.hresp;
   assign O_RTC_PIN     = state_reg.pin;
   assign O_RTC_PIN_OE  = state_reg.pin_oe;
   assign O_ALARM_PULSE = state_reg.alarm_pulse;
   assign O_WAKE_PULSE  = state_reg.wake_pulse;

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!rst_s2_reg);

   a_half_match: assert property ((I_HALF_TICK && mc == RTAM_MASK_HALF && state_reg.ctrl.alarm_en
      && state_reg.ctrl.clock_unit_on) |=> O_ALARM_PULSE) else $error("half second alarm missed"); // RULE1
   a_sec_only_edge: assert property ((mc == RTAM_MASK_SEC && I_HALF_PHASE) |=> !O_ALARM_PULSE)
      else $error("second alarm on half phase"); // RULE1
   a_ten_sec_cmp: assert property ((fire && mc == RTAM_MASK_10S) |-> I_NOW_TIME.sec1 == state_reg.alm.sec1)
      else $error("ten second alarm bad digit"); // RULE2
   a_min_cmp_sec: assert property ((fire && mc == RTAM_MASK_HOUR)
      |-> {I_NOW_TIME.min10, I_NOW_TIME.min1, I_NOW_TIME.sec10, I_NOW_TIME.sec1}
          == {state_reg.alm.min10, state_reg.alm.min1, state_reg.alm.sec10, state_reg.alm.sec1})
      else $error("hourly alarm bad compare"); // RULE3
   a_year_date: assert property ((fire && mc == RTAM_MASK_YEAR)
      |-> I_NOW_TIME.month == state_reg.alm.month && I_NOW_TIME.day == state_reg.alm.day)
      else $error("yearly alarm bad date"); // RULE4
   a_pwc_start: assert property ((fire && pwc_go && state_reg.pwc_st == RTAM_PWC_IDLE)
      |=> state_reg.pwc_st == RTAM_PWC_STAB && O_RTC_PIN == state_reg.ctrl.power_ctl_polarity)
      else $error("power control did not start"); // RULE5
   a_stab_hold: assert property ((state_reg.pwc_st == RTAM_PWC_STAB && !I_HALF_TICK && pwc_go)
      |=> state_reg.pwc_st == RTAM_PWC_STAB) else $error("stabilise window cut short"); // RULE5
   a_pwc_gate: assert property (!pwc_go |=> state_reg.pwc_st == RTAM_PWC_IDLE)
      else $error("power control ran without enables"); // RULE7
   a_pol_level: assert property ((state_reg.ctrl.clock_pin_source_sel == RTAM_SRC_PWC)
      |-> O_RTC_PIN == ((state_reg.pwc_st != RTAM_PWC_IDLE) ~^ state_reg.ctrl.power_ctl_polarity))
      else $error("power pin level wrong"); // RULE8
   a_fine_only: assert property ((fire && mc == RTAM_MASK_DAY)
      |-> I_NOW_TIME.hour == state_reg.alm.hour) else $error("daily alarm hour mismatch"); // RULE11

endmodule : rtam_top

// File: pkg/rtam_pkg.sv
// shared types and constants for the alarm repeat and power control block
package rtam_pkg;

   // register byte addresses
   localparam logic [7:0] RTAM_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] RTAM_ALMMS_ADDR  = 8'h04;
   localparam logic [7:0] RTAM_ALMHD_ADDR  = 8'h08;
   localparam logic [7:0] RTAM_PWCT_ADDR   = 8'h0c;
   localparam logic [7:0] RTAM_STAT_ADDR   = 8'h10;

   // alarm minutes/seconds word field positions
   localparam int RTAM_SEC1_LSB  = 0;
   localparam int RTAM_SEC10_LSB = 4;
   localparam int RTAM_MIN1_LSB  = 8;
   localparam int RTAM_MIN10_LSB = 12;
   // alarm hour/date word field positions
   localparam int RTAM_HOUR_LSB  = 0;
   localparam int RTAM_WDAY_LSB  = 8;
   localparam int RTAM_DAY_LSB   = 16;
   localparam int RTAM_MONTH_LSB = 24;
   // status word field positions
   localparam int RTAM_ST_ALARM  = 0;
   localparam int RTAM_ST_WAKE   = 1;
   localparam int RTAM_ST_BUSY   = 2;
   localparam int RTAM_ST_CNT_LSB = 8;

   // alarm mask codes
   localparam logic [3:0] RTAM_MASK_HALF  = 4'h0;
   localparam logic [3:0] RTAM_MASK_SEC   = 4'h1;
   localparam logic [3:0] RTAM_MASK_10S   = 4'h2;
   localparam logic [3:0] RTAM_MASK_MIN   = 4'h3;
   localparam logic [3:0] RTAM_MASK_10M   = 4'h4;
   localparam logic [3:0] RTAM_MASK_HOUR  = 4'h5;
   localparam logic [3:0] RTAM_MASK_DAY   = 4'h6;
   localparam logic [3:0] RTAM_MASK_WEEK  = 4'h7;
   localparam logic [3:0] RTAM_MASK_MONTH = 4'h8;
   localparam logic [3:0] RTAM_MASK_YEAR  = 4'h9;

   // pin source select codes: power control, alarm pulse, half-second phase
   localparam logic [1:0] RTAM_SRC_PWC    = 2'h3;
   localparam logic [1:0] RTAM_SRC_ALARM  = 2'h0;
   localparam logic [1:0] RTAM_SRC_HALF   = 2'h1;

   // reset values and write masks
   localparam logic [31:0] RTAM_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] RTAM_PWCT_RST  = 32'h0000_0101;
   localparam logic [31:0] RTAM_CTRL_WMSK = 32'h00ff_0fff;
   localparam logic [31:0] RTAM_PWCT_WMSK = 32'h0000_ffff;

   typedef struct packed {
      logic [7:0] rsvd_hi;
      logic [7:0] rpt_cnt;
      logic [3:0] rsvd_mid;
      logic [3:0] alarm_repeat_mask_code;
      logic       alarm_en;
      logic       alarm_repeat_forever;
      logic       power_ctl_polarity;
      logic [1:0] clock_pin_source_sel;
      logic       clock_pin_drive_on;
      logic       power_ctl_on;
      logic       clock_unit_on;
   } rtam_ctrl_t;

   // stabilise and sample windows, in half-second ticks
   typedef struct packed {
      logic [15:0] rsvd;
      logic [7:0]  sample_ticks;
      logic [7:0]  stab_ticks;
   } rtam_pwct_t;

   // bcd calendar time as seen by the comparator
   typedef struct packed {
      logic [4:0] month;
      logic [5:0] day;
      logic [2:0] wday;
      logic [5:0] hour;
      logic [2:0] min10;
      logic [3:0] min1;
      logic [2:0] sec10;
      logic [3:0] sec1;
   } rtam_time_t;

   typedef enum logic [1:0] {
      RTAM_PWC_IDLE,
      RTAM_PWC_STAB,
      RTAM_PWC_SAMPLE
   } rtam_pwc_st_t;

   typedef struct packed {
      logic         hready;
      logic         hresp;
      logic [31:0]  hrdata;
      logic         wr_pend;
      logic [7:0]   wr_addr;
      rtam_ctrl_t   ctrl;
      rtam_time_t   alm;
      rtam_pwct_t   pwct;
      logic         alarm_flag;
      logic         wake_seen;
      rtam_pwc_st_t pwc_st;
      logic [7:0]   pwc_cnt;
      logic         wake_s1;
      logic         wake_s2;
      logic         alarm_pulse;
      logic         wake_pulse;
      logic         pin;
      logic         pin_oe;
   } rtam_state_t;

endpackage : rtam_pkg

// File: src/rtam_fld_cmp.sv
// one calendar field comparison, don't-care when not enabled
`timescale 1ns/1ps
module rtam_fld_cmp
   import rtam_pkg::*;
#(
   parameter int W = 4
)(
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_now,
   input  wire logic [W-1:0] i_alm,
   output logic              o_hit
);

   assign o_hit = !i_en || (i_now == i_alm);

endmodule : rtam_fld_cmp

// File: verif/rtam_ext_dev.sv
// behavioural external peripheral whose supply the clock pin switches
`timescale 1ns/1ps
module rtam_ext_dev #(
   parameter int SETTLE = 12
)(
   input  wire logic i_clk,
   input  wire logic i_pin,
   input  wire logic i_oe,
   input  wire logic i_active_low,
   output logic      o_wake = 1'b0
);
   logic wire_lvl;
   logic powered;
   int   up_cnt = 0;
   // pull to off level
   // an undriven pin floats to the board pull, which is the off level of either polarity
   assign wire_lvl = i_oe ? i_pin : i_active_low;
   assign powered  = (wire_lvl == ~i_active_low);
   // wake only after settling; the wake line has a pull-down, so it reads 0 when unpowered
   always @(posedge i_clk)
   begin
      up_cnt <= powered ? up_cnt + 1 : 0;
      o_wake <= powered && (up_cnt >= SETTLE);
   end
endmodule : rtam_ext_dev

// File: verif/rtam_top_test.sv
// self-checking bench for the alarm repeat and power control block
`timescale 1ns/1ps
module rtam_top_test
   import rtam_pkg::*;
;
   logic        clk     = 1'b0;
   logic        arst_n  = 1'b0;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic        tick    = 1'b0;
   logic        phase   = 1'b0;
   logic        act_low = 1'b0;
   rtam_time_t  now_t   = '0;
   rtam_time_t  alm;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        wake;
   logic        pin;
   logic        pin_oe;
   logic        alarm_p;
   logic        wake_p;
   logic        ap_s;
   logic        pin_s;
   logic        oe_s;
   int          n_mismatch = 0;
   int          tests_run  = 0;
   int          n_wake     = 0;
   int          k;
   int          w0;
   logic [31:0] k_ctl [4] = '{32'h0000_00fe, 32'h0000_00fd, 32'h0000_00fb, 32'h0000_00f7};

   always #2.5 clk = ~clk;
   always @(posedge clk) if (wake_p === 1'b1) n_wake <= n_wake + 1;

   rtam_top uut (
      .I_CLOCK(clk), .I_ARST_N(arst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
      .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_HALF_TICK(tick),
      .I_HALF_PHASE(phase), .I_NOW_TIME(now_t), .I_WAKE(wake), .O_RTC_PIN(pin),
      .O_RTC_PIN_OE(pin_oe), .O_ALARM_PULSE(alarm_p), .O_WAKE_PULSE(wake_p)
   );

   rtam_ext_dev #(.SETTLE(12)) dev (
      .i_clk(clk), .i_pin(pin), .i_oe(pin_oe), .i_active_low(act_low), .o_wake(wake)
   );

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // one single transfer; address held until hready, then data held until hready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100)
      begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(what, exp, r);
      check({what, " resp"}, 32'h0, {31'h0, hresp});
   endtask : rd_chk

   // one half-second tick; outputs sampled in the cycle after the tick edge
   task automatic tick_at(input logic ph, input rtam_time_t t);
      @(posedge clk);
      tick  <= 1'b1;
      phase <= ph;
      now_t <= t;
      @(posedge clk);
      tick <= 1'b0;
      #1;
      ap_s  = alarm_p;
      pin_s = pin;
      oe_s  = pin_oe;
      repeat (6) @(posedge clk);
   endtask : tick_at

   function automatic rtam_time_t alter(input rtam_time_t t, input int f);
      rtam_time_t r;
      r = t;
      case (f)
         0: r.sec1  = t.sec1 ^ 4'h1;
         1: r.sec10 = t.sec10 ^ 3'h1;
         2: r.min1  = t.min1 ^ 4'h1;
         3: r.min10 = t.min10 ^ 3'h1;
         4: r.hour  = t.hour ^ 6'h01;
         5: r.wday  = t.wday ^ 3'h1;
         6: r.day   = t.day ^ 6'h01;
         7: r.month = t.month ^ 5'h01;
         default: r = t;
      endcase
      return r;
   endfunction : alter

   initial
   begin
      alm = '{month:5'h06, day:6'h15, wday:3'h3, hour:6'h12, min10:3'h2, min1:4'h7, sec10:3'h3, sec1:4'h5};
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("oe after reset", 32'h0, {31'h0, pin_oe});
      rd_chk("ctrl reset", RTAM_CTRL_ADDR, 32'h0);
      rd_chk("pwct reset", RTAM_PWCT_ADDR, 32'h0000_0101);
      rd_chk("status reset", RTAM_STAT_ADDR, 32'h0);
      wr(8'h14, 32'hffff_ffff);
      rd_chk("unmapped", 8'h14, 32'h0);
      wr(RTAM_PWCT_ADDR, 32'hffff_0202);
      rd_chk("pwct write", RTAM_PWCT_ADDR, 32'h0000_0202);
      wr(RTAM_ALMMS_ADDR, 32'h0000_2735);
      wr(RTAM_ALMHD_ADDR, 32'h0615_0312);
      rd_chk("alarm hd", RTAM_ALMHD_ADDR, 32'h0615_0312);
      for (int c = 0; c < 16; c++)
      begin
         // pin driven from the alarm pulse source so the pulse is seen on the pin too
         wr(RTAM_CTRL_ADDR, 32'h0000_00c5 | (32'(c) << 8));
         tick_at(1'b0, alm);
         check($sformatf("exact code %0d", c), 32'(c < 10), {31'h0, ap_s});
         check($sformatf("alarm pin %0d", c), 32'h2 | 32'(c < 10), {30'h0, oe_s, pin_s});
         if (c < 2)
         begin
            tick_at(1'b1, alm);
            check($sformatf("second half code %0d", c), 32'(c == 0), {31'h0, ap_s});
         end
         else if (c < 10)
         begin
            tick_at(1'b0, alter(alm, c - 2));
            check($sformatf("finer field code %0d", c), 32'h0, {31'h0, ap_s});
            if (c < 9)
            begin
               tick_at(1'b0, alter(alm, c - 1));
               check($sformatf("coarser field code %0d", c), 32'h1, {31'h0, ap_s});
            end
         end
      end
      wr(RTAM_CTRL_ADDR, 32'h0001_0081);
      for (int i = 0; i < 3; i++)
      begin
         tick_at(1'b1, alm);
         check("counted repeat", 32'(i < 2), {31'h0, ap_s});
      end
      for (int p = 0; p < 2; p++)
      begin
         act_low <= ~p[0];
         wr(RTAM_CTRL_ADDR, 32'h0);
         wr(RTAM_STAT_ADDR, 32'h3);
         w0 = n_wake;
         // forever bit set so the cycle keeps recurring
         wr(RTAM_CTRL_ADDR, 32'h0000_00df | (32'(p) << 5));
         tick_at(1'b0, alm);
         check("pin on", {30'h0, 1'b1, p[0]}, {30'h0, oe_s, pin_s});
         rd_chk("busy", RTAM_STAT_ADDR, 32'h0000_0005);
         k = 0;
         do begin tick_at(1'b0, alm); k++; end while (pin_s === p[0] && k < 10);
         check("on ticks", 32'h4, 32'(k));
         check("pin off", {30'h0, 1'b1, ~p[0]}, {30'h0, oe_s, pin_s});
         check("wake pulses", 32'h1, 32'(n_wake - w0));
         tick_at(1'b0, alm);
         check("autonomous repeat", {31'h0, p[0]}, {31'h0, pin_s});
         wr(RTAM_CTRL_ADDR, 32'h0000_00dd | (32'(p) << 5));
         @(posedge clk);
         #1;
         check("abort off", {31'h0, ~p[0]}, {31'h0, pin});
         rd_chk("status", RTAM_STAT_ADDR, 32'h0000_0003);
      end
      act_low <= 1'b0;
      foreach (k_ctl[i])
      begin
         wr(RTAM_CTRL_ADDR, 32'h0);
         wr(RTAM_CTRL_ADDR, k_ctl[i]);
         tick_at(1'b0, alm);
         check($sformatf("no power ctrl %h", k_ctl[i]), 32'h0, {31'h0, oe_s & pin_s});
      end
      // pin source 01 follows the half-second phase, not power control
      wr(RTAM_CTRL_ADDR, 32'h0000_000d);
      for (int h = 0; h < 2; h++)
      begin
         tick_at(h[0], alm);
         check("half phase pin", {30'h0, 1'b1, h[0]}, {30'h0, oe_s, pin_s});
      end
      report_and_stop();
   end

endmodule : rtam_top_test
